//--- logic/eico_card.sv
// Four-axis index action, input filtering, cascade, interrupt and wait-state logic
`timescale 1ns/1ps

//
// Behaviour
// - INPUT_CONTROL_REG bit4 clear: valid index clears counter
// - INPUT_CONTROL_REG bit4 set: index gates phases A/B
// - INPUT_CONTROL_REG bit5 clear: valid index loads preset
// - INPUT_CONTROL_REG bit5 set: index captures count latch
// - Index polarity selectable per axis
// - Indicator lit while input is low
// - Filter sample rate selectable, 0.625 MHz default
// - Adjacent axes cascadable, off by default
// - Per-axis borrow forwarding, enabled by default
// - Comparator mode blocks borrow interrupt
// - One selectable IRQ2..IRQ7, IRQ3 default
// - Zero/one/two wait states, two default
// - Four-stage digital filter on every encoder input
module eico_card (
   // Clock and reset
   input  wire logic                           sys_clk,
   input  wire logic                           resetn,
   // Register port
   input  wire logic [eico_pkg::ADDR_W-1:0]    sw_addr,
   input  wire logic [eico_pkg::DATA_W-1:0]    sw_wdata,
   input  wire logic                           sw_wr,
   input  wire logic                           sw_rd,
   output logic      [eico_pkg::DATA_W-1:0]    sw_rdata,
   // Encoder pins
   input  wire logic [eico_pkg::AXES-1:0]      enc_a,
   input  wire logic [eico_pkg::AXES-1:0]      enc_b,
   input  wire logic [eico_pkg::AXES-1:0]      enc_idx,
   // Host bus pins
   input  wire logic                           io_cycle_n,
   input  wire logic                           bus_clk_pin,
   output logic                                io_chrdy,
   output logic      [eico_pkg::IRQ_LINES-1:0] irq_req,
   // Indicators and borrow lines
   output logic      [3*eico_pkg::AXES-1:0]    led_on,
   output logic      [eico_pkg::AXES-1:0]      borrow_out
);
   import eico_pkg::*;

   typedef struct packed {
      logic [13:0]                       s1;
      logic [13:0]                       s2;
      logic [11:0][FILT_DEP-1:0]         sh;
      logic [11:0]                       filt;
      logic [11:0]                       fprev;
      logic [ACC_W-1:0]                  acc;
      logic [AXES-1:0][CNT_W-1:0]        cnt;
      logic [AXES-1:0][CNT_W-1:0]        latch;
      logic [AXES-1:0][CNT_W-1:0]        preset;
      logic [15:0]                       axis_cfg;
      logic [CC_W-1:0]                   card_cfg;
      logic [DATA_W-1:0]                 rdata;
      logic [11:0]                       led;
      logic [AXES-1:0]                   bor;
      logic [IRQ_LINES-1:0]              irq;
      logic                              bclk_d;
      logic                              cyc_d;
      logic [1:0]                        ws_cnt;
      logic                              chrdy;
   } eico_st_t;

   eico_st_t st_r;
   eico_st_t st_nxt;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // 4x quadrature decode: returns {up, down}
   function automatic logic [1:0] eico_quad(input logic [3:0] ab);
      case (ab)
         4'b0010, 4'b1011, 4'b1101, 4'b0100: eico_quad = 2'b10;
         4'b0001, 4'b0111, 4'b1110, 4'b1000: eico_quad = 2'b01;
         default:                            eico_quad = 2'b00;
      endcase
   endfunction : eico_quad

   // Sample period in ns for a selection code
   function automatic logic [ACC_W-1:0] eico_period(input logic [2:0] sel);
      case (sel)
         3'h1:    eico_period = PER_1250;
         3'h2:    eico_period = PER_2500;
         3'h3:    eico_period = PER_5000;
         3'h4:    eico_period = PER_10000;
         default: eico_period = PER_0625;
      endcase
   endfunction : eico_period

   // Valid index level after polarity choice
   function automatic logic eico_valid(input logic pin, input logic pol_hi);
      eico_valid = pol_hi ? pin : ~pin;
   endfunction : eico_valid

   // Decoded views of configuration
   logic [2:0]      samp_sel;
   logic [2:0]      irq_sel;
   logic [2:0]      casc;
   logic [AXES-1:0] bfwd;
   logic [AXES-1:0] cmp_mode;
   logic [1:0]      ws_req;
   logic            ws_invalid;
   logic            samp_tick;
   logic            cyc_start;
   logic            bclk_rise;

   assign samp_sel   = st_r.card_cfg[CC_SAMP +: 3];
   assign irq_sel    = st_r.card_cfg[CC_IRQ +: 3];
   assign casc       = st_r.card_cfg[CC_CASC +: 3];
   assign bfwd       = st_r.card_cfg[CC_BFWD +: AXES];
   assign cmp_mode   = st_r.card_cfg[CC_CMP +: AXES];
   assign ws_invalid = st_r.card_cfg[CC_WS1] & st_r.card_cfg[CC_WS2];
   // Both selections together is illegal; fall back to the safe, longer wait
   assign ws_req     = (st_r.card_cfg[CC_WS2] | ws_invalid) ? WS_TWO :
                       (st_r.card_cfg[CC_WS1] ? WS_ONE : WS_NONE);
   // Fractional divider: averages exactly to the chosen rate even at 12.5 cycles
   assign samp_tick  = (st_r.acc + ACC_STEP) >= eico_period(samp_sel);
   assign cyc_start  = st_r.cyc_d & ~st_r.s2[12];
   assign bclk_rise  = ~st_r.bclk_d & st_r.s2[13];

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic [AXES-1:0] carry;
      logic [AXES-1:0] borrow;
      logic [1:0]      q;
      logic            up;
      logic            dn;
      logic            valid;
      logic [3:0]      ac;
      carry  = '0;
      borrow = '0;
      q      = '0;
      up     = 1'b0;
      dn     = 1'b0;
      valid  = 1'b0;
      ac     = '0;
      st_nxt = st_r;

      // Pin synchronisers: second stage feeds all logic
      st_nxt.s1 = {bus_clk_pin, io_cycle_n, enc_idx, enc_b, enc_a};
      st_nxt.s2 = st_r.s1;
      st_nxt.led = ~st_r.s2[11:0];

      // Sample clock accumulator
      st_nxt.acc = samp_tick ? ACC_W'(st_r.acc + ACC_STEP - eico_period(samp_sel))
                             : ACC_W'(st_r.acc + ACC_STEP);

      // Filter: output follows only after four equal samples
      st_nxt.fprev = st_r.filt;
      for (int k = 0; k < 12; k++) begin
         if (samp_tick) begin
            st_nxt.sh[k] = {st_r.sh[k][FILT_DEP-2:0], st_r.s2[k]};
            if (&st_r.sh[k])
               st_nxt.filt[k] = 1'b1;
            else if (~|st_r.sh[k])
               st_nxt.filt[k] = 1'b0;
         end
      end

      // Per-axis counting and index actions, lower axes first for cascade
      for (int i = 0; i < AXES; i++) begin
         ac    = st_r.axis_cfg[4*i +: 4];
         valid = eico_valid(st_r.filt[8+i], ac[AX_POLHI]);
         q     = eico_quad({st_r.fprev[i], st_r.fprev[4+i], st_r.filt[i], st_r.filt[4+i]});
         up    = q[1];
         dn    = q[0];
         if (ac[AX_ROUTE] && ac[AX_ICR4] && !valid) begin
            up = 1'b0;
            dn = 1'b0;
         end
         if (i > 0 && casc[i-1]) begin
            up = carry[i-1];
            dn = borrow[i-1];
         end
         carry[i]  = up & (st_r.cnt[i] == '1);
         borrow[i] = dn & (st_r.cnt[i] == '0);
         if (up)
            st_nxt.cnt[i] = CNT_W'(st_r.cnt[i] + 1'b1);
         else if (dn)
            st_nxt.cnt[i] = CNT_W'(st_r.cnt[i] - 1'b1);
         if (valid && ac[AX_ROUTE] && !ac[AX_ICR4])
            st_nxt.cnt[i] = '0;
         if (valid && !ac[AX_ROUTE] && !ac[AX_ICR5])
            st_nxt.cnt[i] = st_r.preset[i];
         if (valid && !ac[AX_ROUTE] && ac[AX_ICR5])
            st_nxt.latch[i] = st_r.cnt[i];
      end
      // Underflow pulses of every axis, cascaded or not
      st_nxt.bor = borrow;

      // Borrow to the interrupt line: forwarded and not in comparator mode
      st_nxt.irq = '0;
      if (irq_sel < 3'(IRQ_LINES))
         st_nxt.irq[irq_sel] = |(borrow & bfwd & ~cmp_mode);

      // Wait states counted in host bus clocks from the start of a cycle
      st_nxt.cyc_d  = st_r.s2[12];
      st_nxt.bclk_d = st_r.s2[13];
      if (cyc_start) begin
         st_nxt.ws_cnt = ws_req;
      end else if (bclk_rise && st_r.ws_cnt != '0) begin
         st_nxt.ws_cnt = st_r.ws_cnt - 2'h1;
      end
      // The host must hold its strobe while ready is low
      st_nxt.chrdy = (st_nxt.ws_cnt == '0);

      // Register writes
      if (sw_wr) begin
         case (sw_addr)
            OFF_AXIS_CFG: st_nxt.axis_cfg = sw_wdata[15:0];
            OFF_CARD_CFG: begin
               st_nxt.card_cfg = sw_wdata[CC_W-1:0];
               // Restart the divider so a faster rate never sees a stale, larger phase
               st_nxt.acc      = '0;
            end
            default: begin
               for (int i = 0; i < AXES; i++) begin
                  if (sw_addr == 8'(OFF_PRESET + 4*i))
                     st_nxt.preset[i] = sw_wdata[CNT_W-1:0];
               end
            end
         endcase
      end

      // Register reads: data stand only in the cycle after the strobe
      st_nxt.rdata = '0;
      if (sw_rd) begin
         case (sw_addr)
            OFF_AXIS_CFG: st_nxt.rdata = {16'h0000, st_r.axis_cfg};
            OFF_CARD_CFG: st_nxt.rdata = {13'h0000, st_r.card_cfg};
            OFF_STATUS:   st_nxt.rdata = {7'h00, ws_invalid, st_r.filt, st_r.led};
            default: begin
               for (int i = 0; i < AXES; i++) begin
                  if (sw_addr == 8'(OFF_PRESET + 4*i))
                     st_nxt.rdata = {8'h00, st_r.preset[i]};
                  if (sw_addr == 8'(OFF_COUNT + 4*i))
                     st_nxt.rdata = {8'h00, st_r.cnt[i]};
                  if (sw_addr == 8'(OFF_LATCH + 4*i))
                     st_nxt.rdata = {8'h00, st_r.latch[i]};
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Inputs idle high, so filters and synchronisers start high
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r          <= '0;
         st_r.s1       <= '1;
         st_r.s2       <= '1;
         st_r.sh       <= '1;
         st_r.filt     <= '1;
         st_r.fprev    <= '1;
         st_r.cyc_d    <= 1'b1;
         st_r.bclk_d   <= 1'b1;                                         // No false bus clock rise
         st_r.chrdy    <= 1'b1;
         st_r.axis_cfg <= AXIS_CFG_RST;
         st_r.card_cfg <= CARD_CFG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign sw_rdata   = st_r.rdata;
   assign io_chrdy   = st_r.chrdy;
   assign irq_req    = st_r.irq;
   assign led_on     = st_r.led;
   assign borrow_out = st_r.bor;

   // ---------------------------------------------------------------
   // Assertions (axis 0 and 1 watched)
   // ---------------------------------------------------------------
   logic v0;
   assign v0 = eico_valid(st_r.filt[8], st_r.axis_cfg[AX_POLHI]);
   logic v1;
   assign v1 = eico_valid(st_r.filt[9], st_r.axis_cfg[4+AX_POLHI]);

   property p_idx_clear;
      @(posedge sys_clk) disable iff (!resetn)
      (v0 && st_r.axis_cfg[AX_ROUTE] && !st_r.axis_cfg[AX_ICR4]) |=> (st_r.cnt[0] == '0);
   endproperty
   a_idx_clear: assert property (p_idx_clear) else $error("index clear missed");

   property p_idx_gate;
      @(posedge sys_clk) disable iff (!resetn)
      (!v0 && st_r.axis_cfg[AX_ROUTE] && st_r.axis_cfg[AX_ICR4]) |=> $stable(st_r.cnt[0]);
   endproperty
   a_idx_gate: assert property (p_idx_gate) else $error("count moved while gated");

   property p_idx_load;
      @(posedge sys_clk) disable iff (!resetn)
      (v0 && !st_r.axis_cfg[AX_ROUTE] && !st_r.axis_cfg[AX_ICR5])
         |=> (st_r.cnt[0] == $past(st_r.preset[0]));
   endproperty
   a_idx_load: assert property (p_idx_load) else $error("preset load missed");

   property p_idx_latch;
      @(posedge sys_clk) disable iff (!resetn)
      (v0 && !st_r.axis_cfg[AX_ROUTE] && st_r.axis_cfg[AX_ICR5])
         |=> (st_r.latch[0] == $past(st_r.cnt[0]));
   endproperty
   a_idx_latch: assert property (p_idx_latch) else $error("latch capture missed");

   property p_led;
      @(posedge sys_clk) disable iff (!resetn)
      ##2 (led_on == ~$past(st_r.s1[11:0], 2));
   endproperty
   a_led: assert property (p_led) else $error("indicator not low-lit");

   property p_samp;
      @(posedge sys_clk) disable iff (!resetn)
      st_r.acc < eico_period(samp_sel);
   endproperty
   a_samp: assert property (p_samp) else $error("sample accumulator overran");

   property p_filt;
      @(posedge sys_clk) disable iff (!resetn)
      $changed(st_r.filt[0]) |-> ($past(st_r.sh[0]) == {FILT_DEP{st_r.filt[0]}});
   endproperty
   a_filt: assert property (p_filt) else $error("filter passed unstable input");

   property p_casc;
      @(posedge sys_clk) disable iff (!resetn)
      ($past(casc[0] && !v0 && !v1) && borrow_out[0])
         |-> (st_r.cnt[0] == '1) && (st_r.cnt[1] == CNT_W'($past(st_r.cnt[1]) - 1'b1));
   endproperty
   a_casc: assert property (p_casc) else $error("cascade borrow lost");

   property p_irq;
      @(posedge sys_clk) disable iff (!resetn)
      (|irq_req) |-> $past(|(st_nxt.bor & bfwd & ~cmp_mode)) && $onehot(irq_req);
   endproperty
   a_irq: assert property (p_irq) else $error("ungated interrupt");

   property p_wait;
      @(posedge sys_clk) disable iff (!resetn)
      (cyc_start && ws_req != WS_NONE && !bclk_rise) |=> !io_chrdy;
   endproperty
   a_wait: assert property (p_wait) else $error("wait state not inserted");

endmodule : eico_card

//--- logic/eico_pkg.sv
// Shared constants for the encoder index and card option block
package eico_pkg;
   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int          AXES      = 4;
   localparam int          CNT_W     = 24;
   localparam int          FILT_DEP  = 4;
   localparam int          ADDR_W    = 8;
   localparam int          DATA_W    = 32;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0]  OFF_AXIS_CFG = 8'h00;
   localparam logic [7:0]  OFF_CARD_CFG = 8'h04;
   localparam logic [7:0]  OFF_STATUS   = 8'h0C;
   localparam logic [7:0]  OFF_PRESET   = 8'h10;
   localparam logic [7:0]  OFF_COUNT    = 8'h20;
   localparam logic [7:0]  OFF_LATCH    = 8'h30;
   // ---------------------------------------------------------------
   // Axis config: one nibble per axis
   // ---------------------------------------------------------------
   localparam int          AX_ICR4   = 0;
   localparam int          AX_ICR5   = 1;
   localparam int          AX_ROUTE  = 2;
   localparam int          AX_POLHI  = 3;
   localparam logic [15:0] AXIS_CFG_RST = 16'h0080;
   // ---------------------------------------------------------------
   // Card config fields
   // ---------------------------------------------------------------
   localparam int          CC_SAMP   = 0;
   localparam int          CC_IRQ    = 3;
   localparam int          CC_CASC   = 6;
   localparam int          CC_BFWD   = 9;
   localparam int          CC_CMP    = 13;
   localparam int          CC_WS1    = 17;
   localparam int          CC_WS2    = 18;
   localparam int          CC_W      = 19;
   localparam logic [18:0] CARD_CFG_RST = 19'h4_1E08;
   // ---------------------------------------------------------------
   // Sample clock periods in ns, indexed by selection code
   // ---------------------------------------------------------------
   localparam int          CLK_NS    = 8;
   localparam int          ACC_W     = 11;
   localparam logic [10:0] PER_0625  = 11'd1600;
   localparam logic [10:0] PER_1250  = 11'd800;
   localparam logic [10:0] PER_2500  = 11'd400;
   localparam logic [10:0] PER_5000  = 11'd200;
   localparam logic [10:0] PER_10000 = 11'd100;
   localparam logic [10:0] ACC_STEP  = 11'(CLK_NS);
   // ---------------------------------------------------------------
   // Interrupt lines IRQ2..IRQ7 and wait states
   // ---------------------------------------------------------------
   localparam int          IRQ_LINES = 6;
   localparam logic [1:0]  WS_NONE   = 2'h0;
   localparam logic [1:0]  WS_ONE    = 2'h1;
   localparam logic [1:0]  WS_TWO    = 2'h2;
endpackage : eico_pkg

//--- tb/eico_card_tb.sv
// Self-checking bench for index actions, cascade, borrow routing and wait states
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module eico_card_tb;
   import eico_pkg::*;
   localparam logic [31:0] CM = 32'h00FF_FFFF;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  sw_addr = 8'h00;
   logic [31:0] sw_wdata = 32'h0;
   logic        sw_wr = 1'b0;
   logic        sw_rd = 1'b0;
   logic [31:0] sw_rdata;
   logic [3:0]  enc_a, enc_b, enc_idx;
   logic        io_cycle_n = 1'b1;
   logic        bus_clk_pin = 1'b0;
   logic        io_chrdy;
   logic [5:0]  irq_req;
   logic [11:0] led_on;
   logic [3:0]  borrow_out;
   int          mismatches = 0;
   int          num_checks = 0;
   int          bdiv = 0;
   int          r;
   logic        rd_pend = 1'b0;
   logic [63:0] e;
   logic [3:0]  bw_e;
   logic [5:0]  irq_e;
   logic [23:0] pv;
   logic [63:0] rd_q[$];
   logic [3:0]  bw_q[$];
   logic [5:0]  irq_q[$];
   int          wsv[4] = '{2, 1, 0, 3};
   // --------------------------------------------------------------
   // Clocks, design and encoder
   // --------------------------------------------------------------
   always #4 sys_clk = ~sys_clk;
   // Host bus clock, ten system cycles a period
   always @(posedge sys_clk) begin
      bdiv <= (bdiv == 4) ? 0 : bdiv + 1;
      if (bdiv == 4) bus_clk_pin <= ~bus_clk_pin;
   end
   eico_card i_dut (.sys_clk(sys_clk), .resetn(resetn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .enc_a(enc_a), .enc_b(enc_b),
      .enc_idx(enc_idx), .io_cycle_n(io_cycle_n), .bus_clk_pin(bus_clk_pin),
      .io_chrdy(io_chrdy), .irq_req(irq_req), .led_on(led_on), .borrow_out(borrow_out));
   eico_enc_model i_enc (.sys_clk(sys_clk), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx));
   // Watchers take the oldest note whenever a result shows
   always @(posedge sys_clk) begin
      if (rd_pend) begin
         e = rd_q.size() ? rd_q.pop_front() : {32'hFFFF_FFFF, 32'hx};
         `CHK("rdata", e[31:0], sw_rdata & e[63:32]);
      end
      rd_pend <= sw_rd;
      // Pop once into a local so a mismatch does not consume a second note
      if (resetn && borrow_out !== 4'h0) begin
         bw_e = bw_q.size() ? bw_q.pop_front() : 4'hx;
         `CHK("borrow", bw_e, borrow_out);
      end
      if (resetn && irq_req !== 6'h0) begin
         irq_e = irq_q.size() ? irq_q.pop_front() : 6'hx;
         `CHK("irq", irq_e, irq_req);
      end
   end
   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge sys_clk);
      sw_wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   // A gap after each read keeps strobes from being assigned twice in one step
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
      rd_q.push_back({m, ex & m});
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge sys_clk);
      sw_rd <= 1'b0;
      @(posedge sys_clk);
   endtask : rd
   function automatic logic [31:0] cc(int s, int q, int c, int f, int m, int w);
      return 32'(s) | 32'(q) << 3 | 32'(c) << 6 | 32'(f) << 9 | 32'(m) << 13 | 32'(w) << 17;
   endfunction : cc
   task automatic axc(input logic [3:0] n1, input logic [3:0] n0);
      wr(OFF_AXIS_CFG, {16'h0, 8'h88, n1, n0});
   endtask : axc
   // Start just after a bus clock rise so no rise falls inside the sync delay
   task automatic host(input int n);
      int  k;
      logic prev;
      k = 0;
      prev = 1'b1;
      repeat (12) begin
         @(posedge sys_clk);
         if (bus_clk_pin && !prev) break;
         prev = bus_clk_pin;
      end
      io_cycle_n <= 1'b0;
      repeat (40) begin
         @(posedge sys_clk);
         if (bus_clk_pin && !prev && io_chrdy === 1'b0) k++;
         prev = bus_clk_pin;
      end
      `CHK("waits", n, k);
      `CHK("chrdy", 1'b1, io_chrdy);
      io_cycle_n <= 1'b1;
   endtask : host
   task automatic summarize();
      mismatches += rd_q.size() + bw_q.size() + irq_q.size();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   // --------------------------------------------------------------
   // Main sequence and watchdog
   // --------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      summarize();
   end
   initial begin
      r = $urandom(9768);
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      rd(OFF_CARD_CFG, 32'(CARD_CFG_RST), '1);
      rd(OFF_AXIS_CFG, 32'(AXIS_CFG_RST), '1);
      wr(8'hFC, '1);
      rd(8'hFC, 32'h0, '1);
      for (int i = 0; i < 4; i++) begin
         if (i > 0) wr(OFF_CARD_CFG, cc(0, 1, 0, 15, 0, wsv[i]));
         host(wsv[i] == 0 ? 0 : (wsv[i] == 1 ? 1 : 2));
         rd(OFF_STATUS, (wsv[i] == 3) ? 32'h0100_0000 : 32'h0, 32'h0100_0000);
      end
      wr(OFF_CARD_CFG, cc(4, 1, 0, 15, 0, 2));
      r = $urandom;
      // Phase B follows phase A: only 00/11 jumps, so no count and no stray borrow
      r[7:4] = r[3:0];
      i_enc.set_pins(r[3:0], r[7:4], r[11:8]);
      `CHK("led_on", ~r[11:0], led_on);
      rd(OFF_STATUS, 32'(~r[11:0]), 32'h0000_0FFF);
      i_enc.set_pins(4'h0, 4'h0, 4'h0);
      axc(4'h8, 4'hC);
      i_enc.pulse(4'h1, 100);
      rd(OFF_COUNT, 32'h0, CM);
      repeat (3) i_enc.step(0, 1'b1);
      rd(OFF_COUNT, 32'h3, CM);
      i_enc.pulse(4'h1, 5);
      rd(OFF_COUNT, 32'h3, CM);
      i_enc.pulse(4'h1, 100);
      rd(OFF_COUNT, 32'h0, CM);
      axc(4'h8, 4'h4);
      repeat (2) i_enc.step(0, 1'b1);
      rd(OFF_COUNT, 32'h0, CM);
      i_enc.set_pins(enc_a, enc_b, 4'h1);
      repeat (2) i_enc.step(0, 1'b1);
      rd(OFF_COUNT, 32'h2, CM);
      axc(4'h8, 4'hD);
      i_enc.set_pins(enc_a, enc_b, 4'h0);
      repeat (2) i_enc.step(0, 1'b1);
      rd(OFF_COUNT, 32'h2, CM);
      i_enc.set_pins(enc_a, enc_b, 4'h1);
      repeat (2) i_enc.step(0, 1'b1);
      rd(OFF_COUNT, 32'h4, CM);
      i_enc.set_pins(enc_a, enc_b, 4'h0);
      pv = 24'($urandom_range(32'h00FF_FFF0, 1));
      wr(OFF_PRESET, 32'(pv));
      axc(4'h8, 4'h8);
      i_enc.pulse(4'h1, 100);
      rd(OFF_COUNT, 32'(pv), CM);
      axc(4'h8, 4'hA);
      i_enc.step(0, 1'b1);
      i_enc.pulse(4'h1, 100);
      rd(OFF_LATCH, 32'(pv + 24'd1), CM);
      rd(OFF_COUNT, 32'(pv + 24'd1), CM);
      // Borrow routing: default line, random line, comparator mode, forwarding off
      r = $urandom_range(5, 0);
      axc(4'h8, 4'hC);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_CARD_CFG, cc(4, i == 1 ? r : 1, 0, i == 3 ? 14 : 15, i == 2 ? 1 : 0, 2));
         i_enc.pulse(4'h1, 100);
         bw_q.push_back(4'h1);
         if (i < 2) irq_q.push_back(6'h1 << (i == 1 ? r : 1));
         i_enc.step(0, 1'b0);
         rd(OFF_COUNT, CM, CM);
      end
      // Slower rates: a pulse spanning two sample periods is rejected, a long one passes
      for (int s = 3; s >= 0; s--) begin
         wr(OFF_CARD_CFG, cc(s, 1, 0, 15, 0, 2));
         i_enc.pulse(4'h1, 2 * (200 >> s));
         rd(OFF_COUNT, CM, CM);
      end
      i_enc.pulse(4'h1, 1600);
      rd(OFF_COUNT, 32'h0, CM);
      wr(OFF_CARD_CFG, cc(4, 1, 7, 15, 0, 2));
      wr(OFF_PRESET, CM);
      axc(4'h8, 4'h8);
      i_enc.pulse(4'h3, 100);
      i_enc.step(0, 1'b1);
      rd(OFF_COUNT, 32'h0, CM);
      rd(OFF_COUNT + 8'h04, 32'h1, CM);
      // Underflow of the lowest axis borrows from the next and still raises the line
      bw_q.push_back(4'h1);
      irq_q.push_back(6'h2);
      i_enc.step(0, 1'b0);
      rd(OFF_COUNT, CM, CM);
      rd(OFF_COUNT + 8'h04, 32'h0, CM);
      rd(OFF_COUNT + 8'h08, 32'h0, CM);
      repeat (10) @(posedge sys_clk);
      summarize();
   end
endmodule : eico_card_tb

//--- tb/eico_enc_model.sv
// Behavioural four-axis quadrature encoder with index output
`timescale 1ns/1ps
module eico_enc_model #(
   parameter int HOLD = 100   // Held longer than the filter settles at the fastest sample rate
) (
   // Clock
   input  wire logic       sys_clk,
   // Encoder pins
   output logic      [3:0] enc_a,
   output logic      [3:0] enc_b,
   output logic      [3:0] enc_idx
);
   logic [1:0] pos [4];

   // Idle with both phases low and no index
   initial begin
      enc_a   = 4'h0;
      enc_b   = 4'h0;
      enc_idx = 4'h0;
      foreach (pos[k]) pos[k] = 2'd0;
   end

   // One gray step; A leading B is the up direction
   task automatic step(input int ax, input bit up);
      pos[ax] = up ? pos[ax] + 2'd1 : pos[ax] - 2'd1;
      @(posedge sys_clk);
      enc_a[ax] <= pos[ax] inside {2'd1, 2'd2};
      enc_b[ax] <= pos[ax] inside {2'd2, 2'd3};
      repeat (HOLD) @(posedge sys_clk);
   endtask : step

   // Index held for len cycles on the masked axes; short len makes a glitch
   task automatic pulse(input logic [3:0] m, input int len);
      @(posedge sys_clk);
      enc_idx <= enc_idx | m;
      repeat (len) @(posedge sys_clk);
      enc_idx <= enc_idx & ~m;
      repeat (HOLD) @(posedge sys_clk);
   endtask : pulse

   // Raw pin levels; the gray position follows so later steps stay legal
   task automatic set_pins(input logic [3:0] a, input logic [3:0] b, input logic [3:0] i);
      @(posedge sys_clk);
      enc_a   <= a;
      enc_b   <= b;
      enc_idx <= i;
      for (int k = 0; k < 4; k++) pos[k] = {b[k], a[k] ^ b[k]};
      repeat (HOLD) @(posedge sys_clk);
   endtask : set_pins
endmodule : eico_enc_model
